// file: rtl/flash_defines.svh
// Command codes, sizes and counts of the serial flash command interface
`ifndef FLASH_DEFINES_SVH
`define FLASH_DEFINES_SVH
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_STATUS_READ 8'h05
`define CMD_STATUS_WRITE 8'h01
`define CMD_READ 8'h03
`define CMD_FAST_READ 8'h0b
`define CMD_DUAL_READ 8'hbb
`define CMD_QUAD_READ 8'heb
`define CMD_SECTOR_ERASE 8'h20
`define CMD_BLOCK_ERASE 8'hd8
`define CMD_CHIP_ERASE_A 8'h60
`define CMD_CHIP_ERASE_B 8'hc7
`define CMD_PAGE_PROGRAM 8'h02
`define CMD_POWER_DOWN 8'hb9
`define CMD_SIGNATURE_READ 8'hab
`define CMD_MAKER_PART_ID 8'h90
`define CMD_MAKER_PART_ID_DUAL 8'hef
`define CMD_MAKER_PART_ID_QUAD 8'hdf
`define CMD_IDENT_READ 8'h9f
`define ARRAY_AW 21
`define PAGE_AW 8
`define ADDR_BITS 5'h18
`define BYTE_BITS 4'h8
`define PAGE_BYTES 9'h100
`define DUMMY_FAST 4'h8
`define DUMMY_DUAL 4'h4
`define DUMMY_QUAD 4'h6
`define LANES_1 3'h1
`define LANES_2 3'h2
`define LANES_4 3'h4
`define OE_1 4'h2
`define OE_2 4'h3
`define OE_4 4'hf
`define ID_LAST 2'h2
`define ERASED_BYTE 8'hff
`define SECTOR_MASK 21'h000fff
`define BLOCK_MASK 21'h00ffff
`define CHIP_MASK 21'h1fffff
`define SYNC_RESET 6'h20
`endif

// file: rtl/flash_pkg.sv
// Types shared by the serial flash command interface
package flash_pkg;
  typedef struct packed {
    logic spare_io_line3;
    logic wprot_io_line2;
    logic io_line1;
    logic io_line0;
  } sio_t;
  typedef struct packed {
    logic status_write_disable;
    logic quad_enable;
    logic [3:0] protect_level_bits;
    logic write_enable_latch;
    logic op_in_progress;
  } status_t;
  typedef enum logic [5:0] {
    S_CMD = 6'b000001,
    S_ADDR = 6'b000010,
    S_DUMMY = 6'b000100,
    S_DIN = 6'b001000,
    S_DOUT = 6'b010000,
    S_SKIP = 6'b100000
  } ser_st_t;
  typedef enum logic [3:0] {
    A_IDLE = 4'b0001,
    A_PRD = 4'b0010,
    A_PWR = 4'b0100,
    A_ERS = 4'b1000
  } alg_st_t;
endpackage : flash_pkg

// file: rtl/flash_ram.sv
// Single-port byte memory with registered read data and bit-clearing write
`timescale 1ns/1ns
`include "flash_defines.svh"
module flash_ram #(
  parameter int AW = `PAGE_AW,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Access port
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic and_mode,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // And-mode write can only clear bits, like a real program pulse
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= and_mode ? (mem[addr] & wdata) : wdata;
    end
  end

  // Read data always from a register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule : flash_ram

// file: rtl/flash_serial_device.sv
// Serial command interface of a 16-Mbit serial flash, sampled on the system clock
// Notes on behaviour
// - Serial clock may idle low or high; only sampled edges matter.
// - Array has 512 sectors of 4K bytes, each erasable alone.
// - Array has 32 blocks of 64K bytes, each erasable alone.
// - Single-line fast read waits 8 dummy clocks after the address.
// - Dual read waits 4 dummy clocks before two-line data.
// - Quad read waits 6 dummy clocks before four-line data.
// - Program by byte or 256-byte page; erase sector, block or chip.
// - Program and erase run an internal self-timed algorithm.
// - Busy bit in status shows a running program or erase.
// - Dual read uses lines 0 and 1 both ways.
// - Quad read also uses lines 2 and 3 both ways.
// - Serial lines are only heard while select is low.
// - Standby when select high and no operation runs.
// - Four protect-level bits reject program and erase in a region.
// - Identification read returns maker byte then two device bytes.
// - Signature command returns a one-byte device code.
// - Maker/part id reads alternate bytes, maker first at address zero.
// - Changing commands need the write-enable latch; it clears on completion.
// - In power-down only wake release and signature read are heard.
// - Write-protect pin guards status writes unless quad mode is on.
`timescale 1ns/1ns
`include "flash_defines.svh"
module flash_serial_device import flash_pkg::*; #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_TYPE = 8'h3c, // Arbitrary value
  parameter logic [7:0] PART_SIZE = 8'h41, // Arbitrary value
  parameter logic [7:0] PART_SIG = 8'h33 // Arbitrary value
) (
  // System
  input wire logic clk_sys,
  input wire logic reset_n,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire sio_t sio_i,
  output sio_t sio_o,
  output sio_t sio_oe,
  // Status
  output logic op_in_progress,
  output logic write_enable_latch,
  output logic [3:0] protect_level_bits,
  output logic deep_power_down,
  output logic standby
);
  logic [5:0] meta_q, sync_q;
  logic sclk_d_q, cs_d_q;
  logic cs_s, sclk_s, rise, fall, cs_up;
  sio_t pin_s;
  ser_st_t st_q, st_d;
  alg_st_t a_st_q, a_st_d;
  logic [7:0] cmd_q, cmd_d, sh_q, sh_d, ob_q, ob_d, pcol_q, pcol_d, pwr_q, pwr_d;
  logic [3:0] bits_q, bits_d, ocnt_q, ocnt_d, dum_q, dum_d, bp_q, bp_d;
  logic [4:0] cnt_q, cnt_d;
  logic [2:0] w_q, w_d;
  logic [23:0] addr_q, addr_d;
  logic [1:0] idx_q, idx_d;
  logic [8:0] pbn_q, pbn_d, a_idx_q, a_idx_d;
  logic [20:0] a_addr_q, a_addr_d, a_last_q, a_last_d, emask;
  logic done_q, done_d, wel_q, wel_d, qe_q, qe_d, status_write_disable_q, status_write_disable_d, dp_q, dp_d;
  sio_t so_q, so_d, soe_q, soe_d;
  logic busy, go_prog, go_erase, pb_we, a_done, arr_rd, mp_rd;
  logic [7:0] nb, array_rdata, array_wdata, buf_rdata;
  logic [20:0] array_addr;
  logic array_we, array_and;
  logic [7:0] buf_addr;
  status_t sr;

  // Widths 1, 2 or 4 bits shift in MSB first
  function automatic logic [23:0] shift_in(input logic [23:0] v, input sio_t p,
                                           input logic [2:0] w);
    logic [23:0] r;
    r = {v[22:0], p.io_line0};
    if (w == `LANES_2) r = {v[21:0], p.io_line1, p.io_line0};
    if (w == `LANES_4) r = {v[19:0], p};
    return r;
  endfunction : shift_in

  // Protected block map of the four protect-level bits
  function automatic logic blk_protected(input logic [3:0] bp, input logic [4:0] blk);
    logic r;
    case (bp)
      4'h0: r = 1'b0;
      4'h1: r = blk >= 5'h1f;
      4'h2: r = blk >= 5'h1e;
      4'h3: r = blk >= 5'h1c;
      4'h4: r = blk >= 5'h18;
      4'h5: r = blk >= 5'h10;
      4'ha: r = blk <= 5'h0f;
      4'hb: r = blk <= 5'h17;
      4'hc: r = blk <= 5'h1b;
      4'hd: r = blk <= 5'h1d;
      4'he: r = blk <= 5'h1e;
      default: r = 1'b1;
    endcase
    return r;
  endfunction : blk_protected

  // Two-flop synchroniser for select, clock and the four data lines
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= `SYNC_RESET;
      sync_q <= `SYNC_RESET;
      sclk_d_q <= 1'b0;
      cs_d_q <= 1'b1;
    end else begin
      meta_q <= {cs_n, sclk, sio_i};
      sync_q <= meta_q;
      sclk_d_q <= sync_q[4];
      cs_d_q <= sync_q[5];
    end
  end

  // Edge finder works the same for either clock idle level
  assign cs_s = sync_q[5];
  assign sclk_s = sync_q[4];
  assign pin_s = sio_t'(sync_q[3:0]);
  assign rise = !cs_s && sclk_s && !sclk_d_q;
  assign fall = !cs_s && !sclk_s && sclk_d_q;
  assign cs_up = cs_s && !cs_d_q;

  assign busy = (a_st_q != A_IDLE);
  assign sr = {status_write_disable_q, qe_q, bp_q, wel_q, busy};
  assign arr_rd = (cmd_q == `CMD_READ) || (cmd_q == `CMD_FAST_READ) ||
                  (cmd_q == `CMD_DUAL_READ) || (cmd_q == `CMD_QUAD_READ);
  assign mp_rd = (cmd_q == `CMD_MAKER_PART_ID) || (cmd_q == `CMD_MAKER_PART_ID_DUAL) ||
                 (cmd_q == `CMD_MAKER_PART_ID_QUAD);

  // Byte to send next, chosen by the current read command
  always_comb begin
    nb = array_rdata;
    case (cmd_q)
      `CMD_STATUS_READ: nb = sr;
      `CMD_IDENT_READ: nb = (idx_q == 2'h0) ? MAKER_CODE :
                            (idx_q == 2'h1) ? PART_TYPE : PART_SIZE;
      `CMD_SIGNATURE_READ: nb = PART_SIG;
      `CMD_MAKER_PART_ID, `CMD_MAKER_PART_ID_DUAL, `CMD_MAKER_PART_ID_QUAD:
        nb = (idx_q[0] ^ addr_q[0]) ? PART_SIG : MAKER_CODE;
      default: nb = array_rdata;
    endcase
  end

  // Serial command engine and status bits
  always_comb begin
    logic [23:0] lane_v, addr_in;
    logic [7:0] byte_in, ob;
    logic [3:0] bits_nx;
    logic [4:0] cnt_nx;
    status_t nsr;
    lane_v = shift_in({16'h0000, sh_q}, pin_s, w_q);
    addr_in = shift_in(addr_q, pin_s, w_q);
    byte_in = lane_v[7:0];
    bits_nx = bits_q + {1'b0, w_q};
    cnt_nx = cnt_q + {2'b00, w_q};
    nsr = sh_q;
    ob = ob_q;
    st_d = st_q; cmd_d = cmd_q; sh_d = sh_q; bits_d = bits_q; cnt_d = cnt_q;
    dum_d = dum_q; w_d = w_q; addr_d = addr_q; done_d = done_q; ob_d = ob_q;
    ocnt_d = ocnt_q; idx_d = idx_q; pbn_d = pbn_q; pcol_d = pcol_q; pwr_d = pwr_q;
    so_d = so_q; soe_d = soe_q; wel_d = wel_q; bp_d = bp_q; qe_d = qe_q;
    status_write_disable_d = status_write_disable_q; dp_d = dp_q;
    go_prog = 1'b0; go_erase = 1'b0; emask = '0; pb_we = 1'b0;
    if (a_done) wel_d = 1'b0;
    if (cs_s) begin
      // Deselected: lines ignored, outputs released, framing restarts
      st_d = S_CMD; bits_d = '0; cnt_d = '0; w_d = `LANES_1; done_d = 1'b0;
      ocnt_d = '0; soe_d = '0;
      if (cs_up && done_q && bits_q == '0) begin
        case (cmd_q)
          `CMD_WRITE_ENABLE: wel_d = 1'b1;
          `CMD_WRITE_DISABLE: wel_d = 1'b0;
          `CMD_STATUS_WRITE: begin
            // Pin guard only counts while the pin is not a data line
            if (wel_q && !(status_write_disable_q && !pin_s.wprot_io_line2 && !qe_q)) begin
              bp_d = nsr.protect_level_bits;
              qe_d = nsr.quad_enable;
              status_write_disable_d = nsr.status_write_disable;
              wel_d = 1'b0;
            end
          end
          `CMD_PAGE_PROGRAM:
            go_prog = wel_q && pbn_q != '0 && !blk_protected(bp_q, addr_q[20:16]);
          `CMD_SECTOR_ERASE: begin
            go_erase = wel_q && !blk_protected(bp_q, addr_q[20:16]);
            emask = `SECTOR_MASK;
          end
          `CMD_BLOCK_ERASE: begin
            go_erase = wel_q && !blk_protected(bp_q, addr_q[20:16]);
            emask = `BLOCK_MASK;
          end
          `CMD_CHIP_ERASE_A, `CMD_CHIP_ERASE_B: begin
            go_erase = wel_q && bp_q == 4'h0;
            emask = `CHIP_MASK;
          end
          `CMD_POWER_DOWN: dp_d = 1'b1;
          `CMD_SIGNATURE_READ: dp_d = 1'b0;
          default: dp_d = dp_q;
        endcase
      end
    end else if (rise) begin
      case (st_q)
        S_CMD: begin
          sh_d = byte_in;
          bits_d = bits_nx;
          if (bits_nx == `BYTE_BITS) begin
            bits_d = '0; cmd_d = byte_in; idx_d = '0; st_d = S_SKIP; done_d = 1'b1;
            if (dp_q && byte_in != `CMD_SIGNATURE_READ) begin
              done_d = 1'b0;
            end else if (busy && byte_in != `CMD_STATUS_READ) begin
              done_d = 1'b0;
            end else begin
              case (byte_in)
                `CMD_WRITE_ENABLE, `CMD_WRITE_DISABLE, `CMD_CHIP_ERASE_A,
                `CMD_CHIP_ERASE_B, `CMD_POWER_DOWN: st_d = S_SKIP;
                `CMD_STATUS_READ, `CMD_IDENT_READ: st_d = S_DOUT;
                `CMD_STATUS_WRITE: st_d = S_DIN;
                `CMD_READ, `CMD_FAST_READ, `CMD_SECTOR_ERASE, `CMD_BLOCK_ERASE,
                `CMD_PAGE_PROGRAM, `CMD_SIGNATURE_READ, `CMD_MAKER_PART_ID,
                `CMD_MAKER_PART_ID_DUAL, `CMD_MAKER_PART_ID_QUAD: st_d = S_ADDR;
                `CMD_DUAL_READ: begin
                  st_d = S_ADDR;
                  w_d = `LANES_2;
                end
                `CMD_QUAD_READ: begin
                  if (qe_q) begin
                    st_d = S_ADDR;
                    w_d = `LANES_4;
                  end else begin
                    done_d = 1'b0;
                  end
                end
                default: done_d = 1'b0;
              endcase
            end
          end
        end
        S_ADDR: begin
          addr_d = addr_in;
          done_d = 1'b0;
          cnt_d = cnt_nx;
          if (cnt_nx == `ADDR_BITS) begin
            cnt_d = '0;
            st_d = S_DOUT;
            case (cmd_q)
              `CMD_FAST_READ: begin
                st_d = S_DUMMY;
                dum_d = `DUMMY_FAST;
              end
              `CMD_DUAL_READ: begin
                st_d = S_DUMMY;
                dum_d = `DUMMY_DUAL;
              end
              `CMD_QUAD_READ: begin
                st_d = S_DUMMY;
                dum_d = `DUMMY_QUAD;
              end
              `CMD_SECTOR_ERASE, `CMD_BLOCK_ERASE: begin
                st_d = S_SKIP;
                done_d = 1'b1;
              end
              `CMD_PAGE_PROGRAM: begin
                st_d = S_DIN; pbn_d = '0;
                pcol_d = addr_in[7:0]; pwr_d = addr_in[7:0];
              end
              `CMD_SIGNATURE_READ: done_d = 1'b1;
              default: st_d = S_DOUT;
            endcase
          end
        end
        S_DUMMY: begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q + 5'h01 == {1'b0, dum_q}) st_d = S_DOUT;
        end
        S_DIN: begin
          sh_d = byte_in;
          bits_d = bits_nx;
          done_d = 1'b0;
          if (bits_nx == `BYTE_BITS) begin
            bits_d = '0;
            done_d = 1'b1;
            if (cmd_q == `CMD_STATUS_WRITE) begin
              st_d = S_SKIP;
            end else begin
              // Past a full page the column wraps and later bytes win
              pb_we = 1'b1;
              pwr_d = pwr_q + 8'h01;
              if (pbn_q != `PAGE_BYTES) pbn_d = pbn_q + 9'h001;
            end
          end
        end
        S_SKIP: done_d = 1'b0;
        S_DOUT: done_d = done_q;
        default: st_d = S_CMD;
      endcase
    end else if (fall && st_q == S_DOUT) begin
      // Next bits go out on the falling edge; a new byte loads when empty
      if (ocnt_q == '0) begin
        ob = nb;
        ocnt_d = `BYTE_BITS - {1'b0, w_q};
        if (arr_rd) addr_d[20:0] = addr_q[20:0] + 21'h000001;
        idx_d = (idx_q == `ID_LAST || (mp_rd && idx_q[0])) ? 2'h0 : idx_q + 2'h1;
      end else begin
        ob = ob_q << w_q;
        ocnt_d = ocnt_q - {1'b0, w_q};
      end
      ob_d = ob;
      so_d = {2'b00, ob[7], 1'b0};
      soe_d = `OE_1;
      if (w_q == `LANES_2) begin
        so_d = {2'b00, ob[7:6]};
        soe_d = `OE_2;
      end
      if (w_q == `LANES_4) begin
        so_d = ob[7:4];
        soe_d = `OE_4;
      end
    end
  end

  // Self-timed program and erase sequencer
  always_comb begin
    a_st_d = a_st_q; a_idx_d = a_idx_q; a_addr_d = a_addr_q; a_last_d = a_last_q;
    a_done = 1'b0;
    case (a_st_q)
      A_IDLE: begin
        a_idx_d = '0;
        if (go_prog) begin
          a_st_d = A_PRD;
        end else if (go_erase) begin
          a_addr_d = addr_q[20:0] & ~emask;
          a_last_d = addr_q[20:0] | emask;
          a_st_d = A_ERS;
        end
      end
      A_PRD: a_st_d = A_PWR;
      A_PWR: begin
        a_idx_d = a_idx_q + 9'h001;
        a_st_d = A_PRD;
        if (a_idx_q + 9'h001 == pbn_q) begin
          a_st_d = A_IDLE;
          a_done = 1'b1;
        end
      end
      A_ERS: begin
        a_addr_d = a_addr_q + 21'h000001;
        if (a_addr_q == a_last_q) begin
          a_st_d = A_IDLE;
          a_done = 1'b1;
        end
      end
      default: a_st_d = A_IDLE;
    endcase
  end

  // Memory port steering: sequencer owns the array while busy
  always_comb begin
    array_addr = addr_q[20:0];
    array_we = 1'b0;
    array_and = 1'b0;
    array_wdata = `ERASED_BYTE;
    buf_addr = (a_st_q == A_PRD) ? pcol_q + a_idx_q[7:0] : pwr_q;
    if (a_st_q == A_PWR) begin
      array_addr = {addr_q[20:8], pcol_q + a_idx_q[7:0]};
      array_we = 1'b1;
      array_and = 1'b1;
      array_wdata = buf_rdata;
    end
    if (a_st_q == A_ERS) begin
      array_addr = a_addr_q;
      array_we = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= S_CMD; cmd_q <= '0; sh_q <= '0; bits_q <= '0; cnt_q <= '0;
      dum_q <= '0; w_q <= `LANES_1; addr_q <= '0; done_q <= 1'b0; ob_q <= '0;
      ocnt_q <= '0; idx_q <= '0; pbn_q <= '0; pcol_q <= '0; pwr_q <= '0;
      so_q <= '0; soe_q <= '0; wel_q <= 1'b0; bp_q <= '0; qe_q <= 1'b0;
      status_write_disable_q <= 1'b0; dp_q <= 1'b0;
      a_st_q <= A_IDLE; a_idx_q <= '0; a_addr_q <= '0; a_last_q <= '0;
    end else begin
      st_q <= st_d; cmd_q <= cmd_d; sh_q <= sh_d; bits_q <= bits_d; cnt_q <= cnt_d;
      dum_q <= dum_d; w_q <= w_d; addr_q <= addr_d; done_q <= done_d; ob_q <= ob_d;
      ocnt_q <= ocnt_d; idx_q <= idx_d; pbn_q <= pbn_d; pcol_q <= pcol_d; pwr_q <= pwr_d;
      so_q <= so_d; soe_q <= soe_d; wel_q <= wel_d; bp_q <= bp_d; qe_q <= qe_d;
      status_write_disable_q <= status_write_disable_d; dp_q <= dp_d;
      a_st_q <= a_st_d; a_idx_q <= a_idx_d; a_addr_q <= a_addr_d; a_last_q <= a_last_d;
    end
  end

  // Main array, 2M bytes
  flash_ram #(.AW(`ARRAY_AW), .DW(8)) u_array (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .addr(array_addr),
    .we(array_we),
    .and_mode(array_and),
    .wdata(array_wdata),
    .rdata(array_rdata)
  );

  // Page buffer, filled while data bytes arrive
  flash_ram #(.AW(`PAGE_AW), .DW(8)) u_page (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .addr(buf_addr),
    .we(pb_we),
    .and_mode(1'b0),
    .wdata(sh_d),
    .rdata(buf_rdata)
  );

  assign sio_o = so_q;
  assign sio_oe = soe_q;
  assign op_in_progress = busy;
  assign write_enable_latch = wel_q;
  assign protect_level_bits = bp_q;
  assign deep_power_down = dp_q;
  assign standby = cs_s && !busy;
endmodule : flash_serial_device

// file: test/flash_serial_device_asserts.sv
// Port checks for the serial flash command interface
`timescale 1ns/1ns
`include "flash_defines.svh"
module flash_serial_device_asserts import flash_pkg::*; (
  // System
  input wire logic clk_sys,
  input wire logic reset_n,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire sio_t sio_i,
  input wire sio_t sio_o,
  input wire sio_t sio_oe,
  // Status
  input wire logic op_in_progress,
  input wire logic write_enable_latch,
  input wire logic [3:0] protect_level_bits,
  input wire logic deep_power_down,
  input wire logic standby
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // Standby only while idle and deselected
  property p_standby_idle; standby |-> !op_in_progress; endproperty
  a_standby_idle: assert property (p_standby_idle)
    else $error("standby while busy");
  property p_standby_sel; (!cs_n) [*5] |-> !standby; endproperty
  a_standby_sel: assert property (p_standby_sel)
    else $error("standby while selected");
  property p_standby_on; (cs_n && !op_in_progress) [*5] |-> standby; endproperty
  a_standby_on: assert property (p_standby_on)
    else $error("no standby when idle");
  // Lanes are released soon after deselect; sync delay allows a few cycles
  property p_idle_float; cs_n [*6] |-> sio_oe == 4'h0; endproperty
  a_idle_float: assert property (p_idle_float)
    else $error("lane driven while deselected");
  property p_oe_legal; sio_oe inside {4'h0, `OE_1, `OE_2, `OE_4}; endproperty
  a_oe_legal: assert property (p_oe_legal)
    else $error("illegal lane enable set");
  // Commands act only once select has risen
  property p_wel_exec; $rose(write_enable_latch) |-> cs_n; endproperty
  a_wel_exec: assert property (p_wel_exec)
    else $error("latch set while selected");
  property p_busy_start; $rose(op_in_progress) |-> cs_n && write_enable_latch; endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("operation started without latch");
  property p_wel_clear; $fell(op_in_progress) |-> ##[0:2] !write_enable_latch; endproperty
  a_wel_clear: assert property (p_wel_clear)
    else $error("latch kept after completion");
  // Power-down ignores every changing command
  property p_dpd_quiet;
    deep_power_down && $past(deep_power_down) |->
      $stable(write_enable_latch) && $stable(protect_level_bits) && !op_in_progress;
  endproperty
  a_dpd_quiet: assert property (p_dpd_quiet)
    else $error("state changed in power-down");
  // Output data moves only while the serial clock is low
  property p_out_fall; !$stable(sio_o) && sio_oe != 4'h0 && !cs_n |-> !sclk; endproperty
  a_out_fall: assert property (p_out_fall)
    else $error("output changed with clock high");
  c_busy: cover property ($rose(op_in_progress));
  c_quad: cover property (sio_oe == `OE_4);
  c_dpd: cover property ($rose(deep_power_down));
  c_prot: cover property (protect_level_bits != 4'h0);
endmodule : flash_serial_device_asserts
bind flash_serial_device flash_serial_device_asserts u_asserts (
  .clk_sys, .reset_n, .sclk, .cs_n, .sio_i, .sio_o, .sio_oe, .op_in_progress,
  .write_enable_latch, .protect_level_bits, .deep_power_down, .standby
);

// file: test/flash_host_model.sv
// Host controller model that frames commands on the serial link
`timescale 1ns/1ns
module flash_host_model import flash_pkg::*; (
  // Link toward the device
  output logic sclk,
  output logic cs_n,
  // Lanes driven by the host
  output sio_t h_out,
  output sio_t h_oe,
  // Resolved pin levels
  input wire sio_t pin
);
  logic m3;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    h_out = 4'h0;
    h_oe = 4'h0;
    m3 = 1'b0;
  end
  // Select the device with the clock idling low or high
  task open(input logic mode3);
    m3 = mode3;
    // Clock settles at its idle level before select falls, so no false edge
    sclk = mode3;
    #63;
    cs_n = 1'b0;
    #63;
  endtask : open
  // Shift n bits on w lanes; drive after the fall, sample at the rise
  task shift(input logic [31:0] v, input int n, input int w, input logic drv,
             output logic [31:0] r);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    r = 32'h0;
    for (int i = n; i > 0; i -= w) begin
      sclk = 1'b0;
      h_out = 4'(v >> (i - w)) & m;
      h_oe = drv ? m : 4'h0;
      #62;
      sclk = 1'b1;
      r = (r << w) | 32'(w == 1 ? {3'h0, pin.io_line1} : pin & m);
      #63;
    end
  endtask : shift
  // Release lanes and deselect; callers may stop part way through a byte
  task close();
    if (!m3) begin
      sclk = 1'b0;
    end
    h_oe = 4'h0;
    #63;
    cs_n = 1'b1;
    #250;
  endtask : close
endmodule : flash_host_model

// file: test/flash_serial_device_tb.sv
// Self-checking bench for the serial flash command interface
`timescale 1ns/1ns
module flash_serial_device_tb import flash_pkg::*; ;
  // Identity values, arbitrary
  localparam logic [7:0] MK = 8'h6e;
  localparam logic [7:0] PT = 8'h19;
  localparam logic [7:0] PS = 8'h27;
  localparam logic [7:0] SG = 8'h4d;
  logic clk_sys;
  logic reset_n;
  logic sclk;
  logic cs_n;
  logic flt;
  logic m3;
  sio_t h_out;
  sio_t h_oe;
  sio_t pin;
  sio_t sio_o;
  sio_t sio_oe;
  logic op_in_progress;
  logic write_enable_latch;
  logic [3:0] protect_level_bits;
  logic deep_power_down;
  logic standby;
  logic [31:0] r;
  logic [31:0] oe_seen;
  logic [7:0] idc [4] = '{8'h90, 8'hef, 8'hdf, 8'h90};
  int k;
  int n_fail;
  int total_checks;
  flash_serial_device #(.MAKER_CODE(MK), .PART_TYPE(PT), .PART_SIZE(PS), .PART_SIG(SG)) dut (
    .clk_sys, .reset_n, .sclk, .cs_n, .sio_i(pin), .sio_o, .sio_oe, .op_in_progress,
    .write_enable_latch, .protect_level_bits, .deep_power_down, .standby
  );
  flash_host_model host (.sclk, .cs_n, .h_out, .h_oe, .pin);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Released lanes wander every cycle so stale levels never pass for data
  initial flt = 1'b0;
  always @(posedge clk_sys) flt <= ~flt;
  assign pin = (sio_oe & sio_o) | (~sio_oe & h_oe & h_out) | (~sio_oe & ~h_oe & {4{flt}});
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Command, address on w lanes, dummy clocks, then ni bits read
  task xact(input logic [7:0] op, input logic [31:0] a, input int na, input int w,
            input int nd, input int ni);
    logic [31:0] u;
    host.open(m3);
    host.shift({24'h0, op}, 8, 1, 1'b1, u);
    host.shift(a, na, w, 1'b1, u);
    host.shift(32'h0, nd * w, w, 1'b1, u);
    host.shift(32'h0, ni, w, 1'b0, r);
    oe_seen = 32'(sio_oe);
    host.close();
  endtask : xact
  // Poll status until the busy bit drops, bounded
  task wait_idle();
    k = 0;
    do begin
      xact(8'h05, 32'h0, 0, 1, 0, 8);
      k++;
    end while (r[0] === 1'b1 && k < 60);
    check(32'(r[0]), 32'h0);
  endtask : wait_idle
  task tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog well beyond the expected run of about 130 us
  initial begin
    #300000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    reset_n = 1'b0;
    m3 = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    check({standby, write_enable_latch, op_in_progress, deep_power_down}, 32'h8);
    check(32'(sio_oe), 32'h0);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      m3 = i[0];
      xact(8'h9f, 32'h0, 0, 1, 0, 24);
      check(r, {8'h0, MK, PT, PS});
      check(oe_seen, 32'h2);
    end
    m3 = 1'b0;
    xact(8'hab, 32'h0, 24, 1, 0, 8);
    check(r, 32'(SG));
    for (int i = 0; i < 4; i++) begin
      xact(idc[i], 32'(i == 3), 24, 1, 0, 16);
      check(r, i == 3 ? {16'h0, SG, MK} : {16'h0, MK, SG});
    end
    $display("test identity done");
    // Deselected clocks and a ragged command both leave the latch clear
    host.shift(32'h06, 8, 1, 1'b1, r);
    #250;
    check(write_enable_latch, 32'h0);
    host.open(m3);
    host.shift(32'h030, 11, 1, 1'b1, r);
    host.close();
    check(write_enable_latch, 32'h0);
    xact(8'h06, 32'h0, 0, 1, 0, 0);
    check(write_enable_latch, 32'h1);
    xact(8'h04, 32'h0, 0, 1, 0, 0);
    check(write_enable_latch, 32'h0);
    xact(8'h20, 32'h001000, 24, 1, 0, 0);
    check(op_in_progress, 32'h0);
    $display("test latch done");
    // Erase the sector before programming it
    xact(8'h06, 32'h0, 0, 1, 0, 0);
    xact(8'h20, 32'h001000, 24, 1, 0, 0);
    check(op_in_progress, 32'h1);
    wait_idle();
    check(k > 1 && k < 60, 32'h1);
    check(write_enable_latch, 32'h0);
    // Three bytes from the page's next-to-last column wrap to its start
    xact(8'h06, 32'h0, 0, 1, 0, 0);
    host.open(m3);
    host.shift(32'h020010fe, 32, 1, 1'b1, r);
    host.shift(32'ha53c96, 24, 1, 1'b1, r);
    host.close();
    wait_idle();
    check(write_enable_latch, 32'h0);
    xact(8'h03, 32'h0010fe, 24, 1, 0, 24);
    check(r, 32'ha53cff);
    xact(8'h0b, 32'h001000, 24, 1, 8, 16);
    check(r, 32'h96ff);
    xact(8'hbb, 32'h0010fe, 24, 2, 4, 16);
    check(r, 32'ha53c);
    check(oe_seen, 32'h3);
    $display("test program done");
    // Quad enable plus top block protected
    xact(8'h06, 32'h0, 0, 1, 0, 0);
    xact(8'h01, 32'h44, 8, 1, 0, 0);
    check(protect_level_bits, 32'h1);
    check(write_enable_latch, 32'h0);
    xact(8'h06, 32'h0, 0, 1, 0, 0);
    xact(8'h20, 32'h1f0000, 24, 1, 0, 0);
    check(op_in_progress, 32'h0);
    xact(8'hd8, 32'h1f0000, 24, 1, 0, 0);
    check(op_in_progress, 32'h0);
    xact(8'hc7, 32'h0, 0, 1, 0, 0);
    check(op_in_progress, 32'h0);
    xact(8'heb, 32'h0010fe, 24, 4, 6, 16);
    check(r, 32'ha53c);
    check(oe_seen, 32'hf);
    xact(8'h05, 32'h0, 0, 1, 0, 8);
    check(r, 32'h46);
    $display("test protect done");
    xact(8'hb9, 32'h0, 0, 1, 0, 0);
    check(deep_power_down, 32'h1);
    xact(8'h04, 32'h0, 0, 1, 0, 0);
    check(write_enable_latch, 32'h1);
    xact(8'hab, 32'h0, 0, 1, 0, 0);
    check(deep_power_down, 32'h0);
    xact(8'h04, 32'h0, 0, 1, 0, 0);
    check({standby, write_enable_latch}, 32'h2);
    $display("test power-down done");
    tally_and_finish();
  end
endmodule : flash_serial_device_tb
